// ---- design/clk_gen.sv ----
`timescale 1ns/1ps
`include "clk_gen_defines.svh"

module clk_gen
	import clk_gen_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// cycle length from the control pipeline
	input  wire logic [1:0] cycle_len,
	// generated clock
	output logic            sys_clk_n,
	output logic            sys_clk_act
);

	gen_state_t st;      // registered state
	gen_state_t next_st; // next state
	hs_tick_if  hs ();   // high-speed period enable

	// high-speed rate enable
	hs_rate_div u_div (
		.ref_clk (ref_clk),
		.reset   (reset),
		.hs      (hs)
	);

	// hold terms: stage 0 and each stage up to the length, while not yet set, keep the clock high
	// a longer length only adds terms, so no length can cut the forced pair short
	function automatic logic hold_high(input logic [1:0] len, input logic [`CHAIN_LEN-1:0] ch);
		logic h;
		h = ~ch[0];                         // RQ7
		if (len >= 2'h1) h = h | ~ch[1];    // RQ10
		if (len >= 2'h2) h = h | ~ch[2];    // RQ11
		if (len == 2'h3) h = h | ~ch[3];    // RQ11
		return h;                           // RQ9
	endfunction : hold_high

	// live field at the second period, frozen copy after it
	logic [1:0] eff_len; // length in force this period

	// next state, advanced only on high-speed periods
	always_comb begin
		next_st = st;
		// the field is only trusted from the second period on; its live value
		// is used there and then frozen, so later pipeline changes do no harm
		eff_len = (st.chain == `CHAIN_SECOND) ? cycle_len : st.held_len; // RQ8
		// between enables nothing moves, so every level lasts whole high-speed periods
		if (hs.tick) begin
			// inactive period: the next enable always starts a fresh cycle
			if (!st.clk_hi) begin
				next_st.clk_hi  = 1'b1;       // RQ5
				next_st.chain   = `CHAIN_RST; // RQ12
				next_st.act_cnt = 4'h0;
			end else begin
				next_st.chain   = {st.chain[`CHAIN_LEN-2:0], 1'b1}; // RQ6
				next_st.clk_hi  = hold_high(eff_len, st.chain);     // RQ4
				next_st.act_cnt = st.act_cnt + 4'h1;
				if (st.chain == `CHAIN_SECOND) begin
					next_st.held_len = cycle_len; // RQ8
				end
			end
			next_st.sys_clk_n = ~next_st.clk_hi; // RQ13
		end
	end

	// state register; reset parks at an inactive period, so the next enable starts a cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st.clk_hi    <= 1'b0;      // RQ14
			st.chain     <= `CHAIN_RST;// RQ14
			st.held_len  <= `LEN_RST;
			st.sys_clk_n <= 1'b1;
			st.act_cnt   <= 4'h0;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flops; the pin copy is its own flop rather than an
	// inverter on clk_hi, so both outputs leave the block with the same delay
	assign sys_clk_n   = st.sys_clk_n;
	assign sys_clk_act = st.clk_hi;

	// every check below runs on ref_clk and all but a_reset_clears rest while reset is high
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// a low period lasts one high-speed period only
	sequence low_tick;
		hs.tick && !st.clk_hi;
	endsequence

	sequence high_tick;
		hs.tick && st.clk_hi;
	endsequence

	// chain still empty: first active period of a cycle
	sequence chain_empty;
		st.chain == `CHAIN_RST;
	endsequence

	// one stage set: second active period, where the length is taken
	sequence chain_second;
		st.chain == `CHAIN_SECOND;
	endsequence

	// enable that closes the first active period
	sequence first_period;
		high_tick and chain_empty;
	endsequence

	// enable that closes the second active period
	sequence second_period;
		high_tick and chain_second;
	endsequence

	// each length as seen at the second-period enable
	sequence len_seen_zero;
		second_period and (cycle_len == 2'h0);
	endsequence

	sequence len_seen_one;
		second_period and (cycle_len == 2'h1);
	endsequence

	sequence len_seen_two;
		second_period and (cycle_len == 2'h2);
	endsequence

	sequence len_seen_three;
		second_period and (cycle_len == 2'h3);
	endsequence

	// enables that close the third to fifth active periods; the held length rules there
	sequence third_period;
		high_tick and (st.chain == `CHAIN_THIRD);
	endsequence

	sequence fourth_period;
		high_tick and (st.chain == `CHAIN_FOURTH);
	endsequence

	sequence fifth_period;
		high_tick and (st.chain == `CHAIN_FIFTH);
	endsequence

	a_low_goes_high: assert property (low_tick |=> st.clk_hi) // RQ5
		else $error("clock did not return high after one low period");

	a_chain_cleared: assert property (low_tick |=> st.chain == 4'h0) // RQ12
		else $error("timing chain not cleared on inactive period");

	// the first two periods are forced, whatever the field says
	a_second_forced: assert property (first_period |=> st.clk_hi) // RQ7
		else $error("second active period not forced");

	a_len_zero_drop: assert property (len_seen_zero |=> !st.clk_hi) // RQ9
		else $error("length zero did not drop after two periods");

	a_len_one_hold: assert property (len_seen_one |=> st.clk_hi) // RQ10
		else $error("length one did not hold third period");

	a_len_two_hold: assert property (len_seen_two |=> st.clk_hi) // RQ11
		else $error("length two did not hold third period");

	a_len_three_hold: assert property (len_seen_three |=> st.clk_hi) // RQ11
		else $error("length three did not hold third period");

	// later periods follow the length frozen at the second period
	a_len_one_drop: assert property ((third_period and (st.held_len == 2'h1)) |=> !st.clk_hi) // RQ10
		else $error("length one did not drop after three periods");

	a_len_two_stay: assert property ((third_period and (st.held_len >= 2'h2)) |=> st.clk_hi) // RQ11
		else $error("long length did not hold fourth period");

	a_len_two_drop: assert property ((fourth_period and (st.held_len == 2'h2)) |=> !st.clk_hi) // RQ11
		else $error("length two did not drop after four periods");

	a_len_three_stay: assert property ((fourth_period and (st.held_len == 2'h3)) |=> st.clk_hi) // RQ11
		else $error("length three did not hold fifth period");

	a_len_three_drop: assert property (fifth_period |=> !st.clk_hi) // RQ11
		else $error("length three did not drop after five periods");

	// the length is taken once and then left alone
	a_len_latched: assert property (second_period |=> st.held_len == $past(cycle_len)) // RQ8
		else $error("length not taken at second period");

	a_len_frozen: assert property (!(hs.tick && st.clk_hi && st.chain == `CHAIN_SECOND) |=> $stable(st.held_len)) // RQ8
		else $error("held length changed outside second period");

	// state moves only on enables; a new cycle starts its count from zero
	a_state_idle: assert property (!hs.tick |=> $stable(st.clk_hi) && $stable(st.chain)) // RQ1
		else $error("generator moved without a high-speed enable");

	a_fresh_cycle: assert property (low_tick |=> st.act_cnt == 4'h0) // RQ12
		else $error("active count not restarted for a new cycle");

	a_min_active: assert property ($fell(st.clk_hi) |-> st.act_cnt >= 4'(`MIN_ACTIVE)) // RQ4
		else $error("fewer than two active periods");

	a_active_cap: assert property (st.act_cnt <= `MAX_ACTIVE) // RQ4
		else $error("more active periods than the longest length allows");

	a_pin_follows: assert property ($rose(st.clk_hi) |-> $fell(st.sys_clk_n)) // RQ13
		else $error("pin clock did not fall with the internal rise");

	a_active_count: assert property ($fell(st.clk_hi) |-> st.act_cnt == {2'h0, st.held_len} + 4'h2) // RQ11
		else $error("active period count mismatch");

	a_chain_shift: assert property (high_tick |=> st.chain == {$past(st.chain[2:0]), 1'b1}) // RQ6
		else $error("timing chain did not shift");

	a_out_inverted: assert property (st.sys_clk_n != st.clk_hi) // RQ13
		else $error("pin clock not inverse of internal clock");

	a_reset_clears: assert property (disable iff (1'b0) reset |=> !st.clk_hi && st.chain == 4'h0) // RQ14
		else $error("reset did not clear generator");

	a_cycle_bound: assert property ($rose(st.clk_hi) |-> ##[1:30] !st.clk_hi) // RQ4
		else $error("active phase too long");

endmodule : clk_gen

// ---- design/clk_gen_defines.svh ----
// Overview of operation
// RQ1 - cycles built from triple-rate high-speed periods
// RQ2 - nominal 100 ns cycle from 30 MHz
// RQ3 - pipeline supplies two-bit length per instruction
// RQ4 - two or more active, one inactive
// RQ5 - low output flop feeds back high
// RQ6 - four-stage shift chain times extensions
// RQ7 - first chain stage forces second active period
// RQ8 - length field evaluated in second period
// RQ9 - length zero drops after second period
// RQ10 - length one holds via second stage
// RQ11 - length two, three add two, three
// RQ12 - inactive output clears whole chain
// RQ13 - active high inside, inverted at output
// RQ14 - reset clears output and chain stages
`ifndef CLK_GEN_DEFINES_SVH
`define CLK_GEN_DEFINES_SVH

// clock rates in kHz
`define REF_CLK_KHZ   40000
`define HS_CLK_KHZ    30000
`define SYS_CLK_KHZ   10000
// high-speed periods per nominal system cycle
`define HS_PER_SYS    (`HS_CLK_KHZ / `SYS_CLK_KHZ)
// timing chain length and fixed active periods
`define CHAIN_LEN     4
`define MIN_ACTIVE    2
// rate accumulator width
`define ACC_W         16
// reset values
`define CHAIN_RST     4'h0
`define LEN_RST       2'h0
// chain pattern during the second active period
`define CHAIN_SECOND  4'h1
// chain patterns during the third to fifth active periods
`define CHAIN_THIRD   4'h3
`define CHAIN_FOURTH  4'h7
`define CHAIN_FIFTH   4'hF
// most active periods in one cycle, reached by the longest length
`define MAX_ACTIVE    4'h5

`endif

// ---- design/clk_gen_pkg.sv ----
`include "clk_gen_defines.svh"

package clk_gen_pkg;

	// generator state, all in one register
	typedef struct packed {
		logic                    clk_hi;    // internal active-high clock
		logic [`CHAIN_LEN-1:0]   chain;     // timing shift chain
		logic [1:0]              held_len;  // length sampled in second period
		logic                    sys_clk_n; // inverted pin copy
		logic [3:0]              act_cnt;   // active periods seen this cycle
	} gen_state_t;

	// rate divider state
	typedef struct packed {
		logic [`ACC_W-1:0] acc;  // phase accumulator
		logic              tick; // high-speed period enable
	} div_state_t;

endpackage : clk_gen_pkg

// ---- design/hs_tick_if.sv ----
`timescale 1ns/1ps

// carries the high-speed period enable from divider to generator
interface hs_tick_if;
	logic tick; // one-cycle enable per high-speed period
	modport src (output tick);
	modport snk (input tick);
endinterface : hs_tick_if

// ---- design/hs_rate_div.sv ----
`timescale 1ns/1ps
`include "clk_gen_defines.svh"

module hs_rate_div
	import clk_gen_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// enable out
	hs_tick_if.src    hs
);

	div_state_t st;      // registered state
	div_state_t next_st; // next state

	localparam logic [`ACC_W-1:0] REF_STEP = `ACC_W'(`REF_CLK_KHZ); // modulus: one ref period
	localparam logic [`ACC_W-1:0] HS_STEP  = `ACC_W'(`HS_CLK_KHZ);  // RQ2

	// fractional divider: a non-integer ratio is spread as evenly as possible,
	// trading period jitter of one ref cycle for an exact average rate
	always_comb begin
		next_st = st;
		if (st.acc + HS_STEP >= REF_STEP) begin // carry: one period elapsed
			next_st.acc  = st.acc + HS_STEP - REF_STEP;
			next_st.tick = 1'b1; // RQ1
		end else begin
			next_st.acc  = st.acc + HS_STEP;
			next_st.tick = 1'b0;
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign hs.tick = st.tick;

	// a gap is followed by three enables: 30 of every 40 cycles
	sequence three_ticks;
		st.tick ##1 st.tick ##1 st.tick;
	endsequence

	a_tick_rate_ok: assert property (@(posedge ref_clk) disable iff (reset) // RQ2
		!st.tick && $past(!reset) |=> three_ticks)
		else $error("high-speed enable rate wrong");

endmodule : hs_rate_div

// ---- tb/ctl_pipe_model.sv ----
`timescale 1ns/1ps
// control pipeline: loads a length as each system cycle starts
module ctl_pipe_model (
	// generated clock
	input  wire logic       sys_clk_act,
	// length to issue
	input  wire logic [1:0] want_len,
	output logic [1:0]      cycle_len
);
	initial cycle_len = 2'h0;
	// stable through the second active period
	always @(posedge sys_clk_act) #1 cycle_len = want_len;
	// junk once sampled, so a late sample would show
	always @(negedge sys_clk_act) #1 cycle_len = ~want_len;
endmodule : ctl_pipe_model

// ---- tb/clk_gen_tb.sv ----
`timescale 1ns/1ps
module clk_gen_tb;
	logic       ref_clk, reset, prev, started;
	logic [1:0] cycle_len, want_len, l;
	logic       sys_clk_n, sys_clk_act;
	logic [1:0] notes[$]; // one length per started cycle
	int         errors, checks_done, hi_n, cyc_n, mode, i;
	integer     seed; // four-state, as the random seed argument expects

	clk_gen u_clk_gen (.ref_clk(ref_clk), .reset(reset), .cycle_len(cycle_len),
		.sys_clk_n(sys_clk_n), .sys_clk_act(sys_clk_act));
	ctl_pipe_model u_ctl_pipe_model (.sys_clk_act(sys_clk_act), .want_len(want_len),
		.cycle_len(cycle_len));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// ticks come 3 in 4 ref cycles, so a run has a floor or ceiling span
	function automatic logic [7:0] span(input int seen, input int ticks);
		int lo, hi;
		lo = 4 * ticks / 3;
		hi = (4 * ticks + 2) / 3;
		return (seen < lo) ? 8'(lo) : (seen > hi) ? 8'(hi) : 8'(seen);
	endfunction : span

	task automatic conclude;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// note the issued length, then pick the next one
	always @(posedge sys_clk_act) begin
		#1 if (!reset) notes.push_back(want_len);
		#1 want_len = (mode < 4) ? 2'(mode) : 2'($random(seed));
	end

	// measure each cycle in ref_clk periods
	always @(posedge ref_clk) begin
		cyc_n++;
		if (reset)
			started = 1'b0;
		else if (sys_clk_act && !prev) begin
			chk(8'(sys_clk_n), 8'h0);
			if (started && notes.size() > 0) begin
				l = notes.pop_front();
				chk(8'(cyc_n), span(cyc_n, int'(l) + 3));
				chk(8'(cyc_n - hi_n), span(cyc_n - hi_n, 1));
			end
			started = 1'b1;
			cyc_n = 0;
		end else if (!sys_clk_act && prev && started && notes.size() > 0) begin
			hi_n = cyc_n;
			chk(8'(sys_clk_n), 8'h1);
			chk(8'(hi_n), span(hi_n, int'(notes[0]) + 2));
		end
		prev = sys_clk_act;
	end

	initial begin
		reset = 1'b1;
		want_len = 2'h0;
		seed = 32'h34add3bd;
		{errors, checks_done, hi_n, cyc_n, mode} = '0;
		{prev, started} = 2'b00;
		repeat (12) @(posedge ref_clk);
		#1 reset = 1'b0;
		// every length held, then random lengths back to back
		for (i = 0; i < 5; i++) begin
			mode = i;
			repeat (4) @(posedge sys_clk_act);
		end
		repeat (30) @(posedge sys_clk_act);
		// second reset in mid-run
		@(posedge ref_clk);
		#1 reset = 1'b1;
		notes.delete();
		repeat (2) @(posedge ref_clk);
		#1 chk(8'({sys_clk_n, sys_clk_act}), 8'h2);
		#1 reset = 1'b0;
		repeat (15) @(posedge sys_clk_act);
		conclude();
	end

	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#100000;
		errors++;
		conclude();
	end
endmodule : clk_gen_tb
